// ==== rtck_consts.vh ====
`ifndef RTCK_CONSTS_VH
`define RTCK_CONSTS_VH
// register index; byte address is four times the index
`define RTCK_IDX_SEC 4'h0
`define RTCK_IDX_MIN 4'h1
`define RTCK_IDX_HOUR 4'h2
`define RTCK_IDX_WDAY 4'h3
`define RTCK_IDX_MDAY 4'h4
`define RTCK_IDX_MON 4'h5
`define RTCK_IDX_YEAR 4'h6
`define RTCK_IDX_CTRL1 4'he
`define RTCK_IDX_CTRL2 4'hf
// implemented bits per counter
`define RTCK_MSK_SEC 8'h7f
`define RTCK_MSK_MIN 8'h7f
`define RTCK_MSK_HOUR 8'h3f
`define RTCK_MSK_WDAY 8'h07
`define RTCK_MSK_MDAY 8'h3f
`define RTCK_MSK_MON 8'h1f
`define RTCK_MSK_YEAR 8'hff
// control 1 fields
`define RTCK_C1_AAE 7
`define RTCK_C1_BAE 6
`define RTCK_C1_H24 5
`define RTCK_C1_CLK_OUT_ENABLE_N_B 4
// control 2 fields
`define RTCK_C2_SCR 7
`define RTCK_C2_SUPPLY_LOW_FLAG 6
`define RTCK_C2_OSC_HALT_FLAG 5
`define RTCK_C2_PON 4
`define RTCK_C2_CLK_OUT_ENABLE_N_A 3
`define RTCK_C2_PERIODIC_IRQ_FLAG 2
`define RTCK_C2_ALARM_A_FLAG 1
`define RTCK_C2_ALARM_B_FLAG 0
// periodic select codes
`define RTCK_PS_OFF 3'h0
`define RTCK_PS_LOW 3'h1
`define RTCK_PS_2HZ 3'h2
`define RTCK_PS_1HZ 3'h3
// reset values
`define RTCK_RST_TIME 8'h00
`define RTCK_RST_DATE 8'h01
// timing
`define RTCK_CLK_HZ 25000000
`define RTCK_ALARM_DLY_NS 15000
`define RTCK_HALT_NS 100000
// bus responses
`define RTCK_RESP_OK 2'h0
`define RTCK_RESP_ERR 2'h2
`endif

// ==== rtck_core.v ====
// Function
// - oscillator halt sets halt flag; only a written 0 clears it
// - power-on flag is 1 after power-up until host clears it
// - while power-on flag is 1, control bits held zero; interrupts stop
// - power-on flag cleared only by writing 0; writing 1 ignored
// - clock out follows oscillator when an enable_n is 0 and control pin high
// - periodic flag reads 1 exactly while periodic output is low
// - level mode: writing 0 to periodic flag releases output until next cycle
// - enabled alarm flag sets about 15 us after time match
// - writing 0 to alarm flag releases its output until next match
// - alarm flag reads 0 while its enable bit is 0
// - seconds and minutes count BCD 00..59 and carry on wrap
// - hours carry to day counters at 23->00 or PM11->AM12
// - any seconds write resets sub-second prescaler
// - weekday counts 0..6 on each day carry and wraps after 6
// - day of month wraps after month length, leap aware, carrying to month
// - month counts 1..12 and carries into year on wrap
// - calendar counters read in packed BCD
// - mode bit 0 selects 12-hour, 1 selects 24-hour; bit 5 is p.m.
// - level mode asserts once per selected interval until cleared
`include "rtck_consts.vh"
module rtck_core #(
  parameter AW = 8,
  parameter PW = 15
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite slave
  input wire [AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // oscillator and pins
  input wire osc_clk_in,
  input wire clk_out_control_pin,
  input wire supply_low_in,
  input wire alarm_a_match,
  input wire alarm_b_match,
  output reg crystal_clock_out_pin,
  output reg irq_out_a_n,
  output reg irq_out_b_n
);
  localparam integer ALARM_DLY_CYC = (`RTCK_ALARM_DLY_NS * (`RTCK_CLK_HZ / 1000000)) / 1000;
  localparam integer HALT_CYC = (`RTCK_HALT_NS * (`RTCK_CLK_HZ / 1000000)) / 1000;

  function is_mapped;
    input [AW-1:0] a;
    begin
      is_mapped = (a[AW-1:6] == 0) && ((a[5:2] <= `RTCK_IDX_YEAR) ||
        (a[5:2] == `RTCK_IDX_CTRL1) || (a[5:2] == `RTCK_IDX_CTRL2));
    end
  endfunction

  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9) begin
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
        bcd_inc = v + 8'h01;
      end
    end
  endfunction

  function [7:0] month_len;
    input [7:0] mon;
    input [7:0] yr;
    reg leap;
    begin
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) :
        (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
      if (mon == 8'h02) begin
        month_len = leap ? 8'h29 : 8'h28;
      end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11) begin
        month_len = 8'h30;
      end else begin
        month_len = 8'h31;
      end
    end
  endfunction

  // synchronisers
  reg osc_s1_q, osc_s2_q, osc_s3_q;
  reg clk_out_control_pin_s1_q, clk_out_control_pin_s2_q;
  reg vlow_s1_q, vlow_s2_q;
  // bus state
  reg [AW-1:0] awaddr_q;
  reg [7:0] wdata_q;
  reg wlane_q;
  // timekeeping
  reg [PW-1:0] presc_q;
  reg [11:0] halt_cnt_q;
  reg [7:0] sec_q, min_q, hour_q, wday_q, mday_q, mon_q, year_q;
  reg [7:0] ctrl1_q;
  reg scratch_q, clk_out_enable_n_a_q, pon_q, osc_halt_flag_q, supply_low_flag_q;
  reg per_low_q, alarm_a_q, alarm_b_q;
  reg am_a_q, am_b_q;
  reg [8:0] dly_a_q, dly_b_q;

  wire do_wr = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire wr_ok = do_wr & wlane_q & is_mapped(awaddr_q);
  wire [3:0] widx = awaddr_q[5:2];
  wire wr_sec = wr_ok & (widx == `RTCK_IDX_SEC);
  wire wr_c1 = wr_ok & (widx == `RTCK_IDX_CTRL1);
  wire wr_c2 = wr_ok & (widx == `RTCK_IDX_CTRL2);
  wire osc_rise = osc_s2_q & ~osc_s3_q;
  wire tick = osc_rise & (&presc_q) & ~wr_sec;
  wire h24 = ctrl1_q[`RTCK_C1_H24];
  wire [2:0] psel = ctrl1_q[2:0];
  wire c_min = tick & (sec_q == 8'h59);
  wire c_hour = c_min & (min_q == 8'h59);
  wire c_day = c_hour & (h24 ? (hour_q == 8'h23) : (hour_q == 8'h31));
  wire c_mon = c_day & (mday_q == month_len(mon_q, year_q));
  wire c_year = c_mon & (mon_q == 8'h12);
  wire halt_det = ~osc_rise & (halt_cnt_q == HALT_CYC[11:0] - 12'h001);
  wire clr_periodic_irq_flag = wr_c2 & ~wdata_q[`RTCK_C2_PERIODIC_IRQ_FLAG];
  wire clr_a = wr_c2 & ~wdata_q[`RTCK_C2_ALARM_A_FLAG];
  wire clr_b = wr_c2 & ~wdata_q[`RTCK_C2_ALARM_B_FLAG];

  reg [7:0] hour_nx;
  reg per_ev;
  always @* begin
    hour_nx = bcd_inc(hour_q);
    if (h24) begin
      if (hour_q == 8'h23) begin
        hour_nx = 8'h00;
      end
    end else begin
      case (hour_q)
        8'h11: hour_nx = 8'h32;
        8'h31: hour_nx = 8'h12;
        8'h12: hour_nx = 8'h01;
        8'h32: hour_nx = 8'h21;
        default: hour_nx = bcd_inc(hour_q);
      endcase
    end
    case (psel[1:0])
      2'h0: per_ev = tick;
      2'h1: per_ev = c_min;
      2'h2: per_ev = c_hour;
      default: per_ev = c_mon;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
      clk_out_control_pin_s1_q <= 1'b0;
      clk_out_control_pin_s2_q <= 1'b0;
      vlow_s1_q <= 1'b0;
      vlow_s2_q <= 1'b0;
    end else begin
      osc_s1_q <= osc_clk_in;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
      clk_out_control_pin_s1_q <= clk_out_control_pin;
      clk_out_control_pin_s2_q <= clk_out_control_pin_s1_q;
      vlow_s1_q <= supply_low_in;
      vlow_s2_q <= vlow_s1_q;
    end
  end

  // axi4-lite slave: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RTCK_RESP_OK;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RTCK_RESP_OK;
      s_axi_rdata <= 32'h0;
      awaddr_q <= {AW{1'b0}};
      wdata_q <= 8'h00;
      wlane_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(awaddr_q) ? `RTCK_RESP_OK : `RTCK_RESP_ERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= is_mapped(s_axi_araddr) ? `RTCK_RESP_OK : `RTCK_RESP_ERR;
        case (is_mapped(s_axi_araddr) ? s_axi_araddr[5:2] : 4'h7)
          `RTCK_IDX_SEC: s_axi_rdata <= {24'h0, sec_q};
          `RTCK_IDX_MIN: s_axi_rdata <= {24'h0, min_q};
          `RTCK_IDX_HOUR: s_axi_rdata <= {24'h0, hour_q};
          `RTCK_IDX_WDAY: s_axi_rdata <= {24'h0, wday_q};
          `RTCK_IDX_MDAY: s_axi_rdata <= {24'h0, mday_q};
          `RTCK_IDX_MON: s_axi_rdata <= {24'h0, mon_q};
          `RTCK_IDX_YEAR: s_axi_rdata <= {24'h0, year_q};
          `RTCK_IDX_CTRL1: s_axi_rdata <= {24'h0, ctrl1_q};
          `RTCK_IDX_CTRL2: s_axi_rdata <= {24'h0, scratch_q, supply_low_flag_q, osc_halt_flag_q, pon_q,
            clk_out_enable_n_a_q, per_low_q, alarm_a_q, alarm_b_q};
          default: s_axi_rdata <= 32'h0;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // prescaler and halt watchdog
  always @(posedge aclk) begin
    if (!aresetn) begin
      presc_q <= {PW{1'b0}};
      halt_cnt_q <= 12'h000;
    end else begin
      if (wr_sec) begin
        presc_q <= {PW{1'b0}};
      end else if (osc_rise) begin
        presc_q <= presc_q + {{(PW-1){1'b0}}, 1'b1};
      end
      if (osc_rise) begin
        halt_cnt_q <= 12'h000;
      end else if (halt_cnt_q != HALT_CYC[11:0]) begin
        halt_cnt_q <= halt_cnt_q + 12'h001;
      end
    end
  end

  // time and calendar counters; a host write wins over a carry
  always @(posedge aclk) begin
    if (!aresetn) begin
      sec_q <= `RTCK_RST_TIME;
      min_q <= `RTCK_RST_TIME;
      hour_q <= `RTCK_RST_TIME;
      wday_q <= `RTCK_RST_TIME;
      mday_q <= `RTCK_RST_DATE;
      mon_q <= `RTCK_RST_DATE;
      year_q <= `RTCK_RST_TIME;
    end else begin
      if (wr_sec) begin
        sec_q <= wdata_q & `RTCK_MSK_SEC;
      end else if (tick) begin
        sec_q <= c_min ? 8'h00 : bcd_inc(sec_q);
      end
      if (wr_ok && widx == `RTCK_IDX_MIN) begin
        min_q <= wdata_q & `RTCK_MSK_MIN;
      end else if (c_min) begin
        min_q <= c_hour ? 8'h00 : bcd_inc(min_q);
      end
      if (wr_ok && widx == `RTCK_IDX_HOUR) begin
        hour_q <= wdata_q & `RTCK_MSK_HOUR;
      end else if (c_hour) begin
        hour_q <= hour_nx;
      end
      if (wr_ok && widx == `RTCK_IDX_WDAY) begin
        wday_q <= wdata_q & `RTCK_MSK_WDAY;
      end else if (c_day) begin
        wday_q <= (wday_q >= 8'h06) ? 8'h00 : wday_q + 8'h01;
      end
      if (wr_ok && widx == `RTCK_IDX_MDAY) begin
        mday_q <= wdata_q & `RTCK_MSK_MDAY;
      end else if (c_day) begin
        mday_q <= c_mon ? 8'h01 : bcd_inc(mday_q);
      end
      if (wr_ok && widx == `RTCK_IDX_MON) begin
        mon_q <= wdata_q & `RTCK_MSK_MON;
      end else if (c_mon) begin
        mon_q <= c_year ? 8'h01 : bcd_inc(mon_q);
      end
      if (wr_ok && widx == `RTCK_IDX_YEAR) begin
        year_q <= wdata_q & `RTCK_MSK_YEAR;
      end else if (c_year) begin
        year_q <= (year_q == 8'h99) ? 8'h00 : bcd_inc(year_q);
      end
    end
  end

  // status and control; hardware set wins over a written clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      pon_q <= 1'b1;
      osc_halt_flag_q <= 1'b1;
      supply_low_flag_q <= 1'b1;
      ctrl1_q <= 8'h00;
      scratch_q <= 1'b0;
      clk_out_enable_n_a_q <= 1'b0;
      per_low_q <= 1'b0;
      alarm_a_q <= 1'b0;
      alarm_b_q <= 1'b0;
      am_a_q <= 1'b0;
      am_b_q <= 1'b0;
      dly_a_q <= 9'h000;
      dly_b_q <= 9'h000;
    end else begin
      pon_q <= pon_q & ~(wr_c2 & ~wdata_q[`RTCK_C2_PON]);
      osc_halt_flag_q <= (osc_halt_flag_q & ~(wr_c2 & ~wdata_q[`RTCK_C2_OSC_HALT_FLAG])) | halt_det;
      supply_low_flag_q <= (supply_low_flag_q & ~(wr_c2 & ~wdata_q[`RTCK_C2_SUPPLY_LOW_FLAG])) | vlow_s2_q;
      am_a_q <= alarm_a_match;
      am_b_q <= alarm_b_match;
      // match edge starts the settling delay
      if (alarm_a_match && !am_a_q) begin
        dly_a_q <= ALARM_DLY_CYC[8:0];
      end else if (dly_a_q != 9'h000) begin
        dly_a_q <= dly_a_q - 9'h001;
      end
      if (alarm_b_match && !am_b_q) begin
        dly_b_q <= ALARM_DLY_CYC[8:0];
      end else if (dly_b_q != 9'h000) begin
        dly_b_q <= dly_b_q - 9'h001;
      end
      if (pon_q) begin
        ctrl1_q <= 8'h00;
        scratch_q <= 1'b0;
        clk_out_enable_n_a_q <= 1'b0;
        per_low_q <= 1'b0;
        alarm_a_q <= 1'b0;
        alarm_b_q <= 1'b0;
      end else begin
        if (wr_c1) begin
          ctrl1_q <= wdata_q;
        end
        if (wr_c2) begin
          scratch_q <= wdata_q[`RTCK_C2_SCR];
          clk_out_enable_n_a_q <= wdata_q[`RTCK_C2_CLK_OUT_ENABLE_N_A];
        end
        case (psel)
          `RTCK_PS_OFF: per_low_q <= 1'b0;
          `RTCK_PS_LOW: per_low_q <= 1'b1;
          `RTCK_PS_2HZ: per_low_q <= ~presc_q[PW-2];
          `RTCK_PS_1HZ: per_low_q <= ~presc_q[PW-1];
          default: per_low_q <= (per_low_q & ~clr_periodic_irq_flag) | per_ev;
        endcase
        alarm_a_q <= ctrl1_q[`RTCK_C1_AAE] &
          ((alarm_a_q & ~clr_a) | (dly_a_q == 9'h001));
        alarm_b_q <= ctrl1_q[`RTCK_C1_BAE] &
          ((alarm_b_q & ~clr_b) | (dly_b_q == 9'h001));
      end
    end
  end

  // pin outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      crystal_clock_out_pin <= 1'b0;
      irq_out_a_n <= 1'b1;
      irq_out_b_n <= 1'b1;
    end else begin
      crystal_clock_out_pin <= osc_s2_q & clk_out_control_pin_s2_q &
        ~(clk_out_enable_n_a_q & ctrl1_q[`RTCK_C1_CLK_OUT_ENABLE_N_B]);
      irq_out_a_n <= ~(per_low_q | alarm_a_q);
      irq_out_b_n <= ~alarm_b_q;
    end
  end
endmodule // rtck_core

// ==== rtck_osc_model.sv ====
module rtck_osc_model (
  // control
  input wire run,
  // oscillator
  output logic osc
);
  timeunit 1ns;
  timeprecision 1ps;
  // 320 ns period, phase unrelated to aclk; parks low while halted
  initial begin
    osc = 1'b0;
    #7;
    forever begin
      #160;
      osc = run ? ~osc : 1'b0;
    end
  end
endmodule // rtck_osc_model

// ==== rtck_core_assertions.sv ====
`include "rtck_consts.vh"
module rtck_core_chk #(
  parameter AW = 8
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // register bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // pins
  input wire clk_out_control_pin,
  input wire alarm_b_match,
  input wire crystal_clock_out_pin,
  input wire irq_out_a_n,
  input wire irq_out_b_n
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire rd_take = s_axi_arvalid && s_axi_arready;
  wire rd_hole = s_axi_araddr[5:2] > 4'h6 && s_axi_araddr[5:2] < 4'he;
  a_write_resp: assert property (wr_take |-> ##2 s_axi_bvalid)
    else $error("write response not issued on time");
  a_read_resp: assert property (rd_take |=> s_axi_rvalid)
    else $error("read data not issued on time");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_unmapped_read: assert property (rd_take && rd_hole |=>
    s_axi_rresp == `RTCK_RESP_ERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_clkout_off: assert property (!clk_out_control_pin [*5] |-> !crystal_clock_out_pin)
    else $error("clock out active with control pin low");
  a_clkout_src: assert property ($rose(crystal_clock_out_pin) |->
    $past(clk_out_control_pin, 2) || $past(clk_out_control_pin, 3) || $past(clk_out_control_pin, 4))
    else $error("clock out rose without control pin");
  a_reset_idle: assert property (disable iff (1'b0) !aresetn |=>
    irq_out_a_n && irq_out_b_n && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not idle under reset");
  a_alarm_early: assert property ($rose(alarm_b_match) && irq_out_b_n |=> irq_out_b_n [*8])
    else $error("alarm output asserted too early");
  c_err: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == `RTCK_RESP_ERR);
  c_irq_a: cover property ($fell(irq_out_a_n));
  c_irq_b: cover property ($fell(irq_out_b_n));
endmodule // rtck_core_chk

// ==== rtc_timekeeping_and_flags_tb_top.sv ====
`include "rtck_consts.vh"
module rtc_timekeeping_and_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] C1 = `RTCK_IDX_CTRL1;
  localparam logic [3:0] C2 = `RTCK_IDX_CTRL2;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, osc_run, osc, clk_pin, m_a, m_b;
  logic clk_out, irq_a_n, irq_b_n;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [1:0] bresp, rresp, rsp;
  int n_mismatch, num_checks, cyc, ones;
  // ctrl1, hour, wday, mday, month, year, then expected hour..year after the tick
  logic [7:0] tc [5][11] = '{
    '{8'h00, 8'h31, 8'h02, 8'h28, 8'h02, 8'h00, 8'h12, 8'h03, 8'h29, 8'h02, 8'h00},
    '{8'h20, 8'h23, 8'h06, 8'h28, 8'h02, 8'h01, 8'h00, 8'h00, 8'h01, 8'h03, 8'h01},
    '{8'h20, 8'h23, 8'h00, 8'h31, 8'h12, 8'h99, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00},
    '{8'h20, 8'h23, 8'h01, 8'h30, 8'h04, 8'h04, 8'h00, 8'h02, 8'h01, 8'h05, 8'h04},
    '{8'h00, 8'h11, 8'h03, 8'h15, 8'h06, 8'h23, 8'h32, 8'h03, 8'h15, 8'h06, 8'h23}};
  rtck_core #(.AW(8), .PW(4)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .osc_clk_in(osc), .clk_out_control_pin(clk_pin), .supply_low_in(1'b0),
    .alarm_a_match(m_a), .alarm_b_match(m_b), .crystal_clock_out_pin(clk_out),
    .irq_out_a_n(irq_a_n), .irq_out_b_n(irq_b_n));
  rtck_osc_model osc_m (.run(osc_run), .osc(osc));
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic end_sim;
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic w(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    logic a, b;
    a = 1'b1;
    b = 1'b1;
    awaddr <= {2'h0, i, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (a || b) begin
      @(posedge aclk);
      if (a && awready) begin
        a = 1'b0;
        awvalid <= 1'b0;
      end
      if (b && wready) begin
        b = 1'b0;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge aclk);
    rsp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rdc(input logic [3:0] i, input logic [7:0] e);
    araddr <= {2'h0, i, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    v = rdata;
    rsp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
    chk(v, {24'h0, e});
  endtask
  task automatic cnt(input logic e);
    ones = 0;
    w(6);
    repeat (40) begin
      @(posedge aclk);
      ones += clk_out;
    end
    chk(ones != 0, e);
  endtask
  task automatic hit(input logic b);
    if (b)
      m_b <= 1'b1;
    else
      m_a <= 1'b1;
    w(3);
    m_a <= 1'b0;
    m_b <= 1'b0;
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, clk_pin, m_a, m_b} = '0;
    {awaddr, araddr, wdata} = '0;
    osc_run = 1'b1;
    {n_mismatch, num_checks, cyc} = '0;
    w(8);
    aresetn <= 1'b1;
    w(1);
    rdc(C2, 8'h70);
    wr(C1, 8'hff);
    rdc(C1, 8'h00);
    wr(C2, 8'hff);
    rdc(C2, 8'h70);
    chk({irq_a_n, irq_b_n}, 2'h3);
    wr(4'h8, 8'h5a);
    chk(rsp, `RTCK_RESP_ERR);
    rdc(4'h8, 8'h00);
    chk(rsp, `RTCK_RESP_ERR);
    wr(C2, 8'h00);
    chk(rsp, `RTCK_RESP_OK);
    rdc(C2, 8'h00);
    clk_pin <= 1'b1;
    cnt(1'b1);
    wr(C1, 8'h10);
    cnt(1'b1);
    wr(C2, 8'h08);
    cnt(1'b0);
    wr(C1, 8'h00);
    cnt(1'b1);
    clk_pin <= 1'b0;
    cnt(1'b0);
    wr(C2, 8'h00);
    wr(`RTCK_IDX_WDAY, 8'hf5);
    rdc(`RTCK_IDX_WDAY, 8'h05);
    for (int k = 0; k < 5; k++) begin
      wr(C1, tc[k][0]);
      for (int j = 1; j < 6; j++) wr(4'(j + 1), tc[k][j]);
      wr(`RTCK_IDX_MIN, 8'h59);
      wr(`RTCK_IDX_SEC, 8'h59);
      w(200);
      rdc(`RTCK_IDX_SEC, 8'h00);
      rdc(`RTCK_IDX_MIN, 8'h00);
      for (int j = 0; j < 5; j++) rdc(4'(j + 2), tc[k][j + 6]);
    end
    wr(`RTCK_IDX_SEC, 8'h10);
    w(100);
    wr(`RTCK_IDX_SEC, 8'h10);
    w(100);
    rdc(`RTCK_IDX_SEC, 8'h10);
    w(60);
    rdc(`RTCK_IDX_SEC, 8'h11);
    wr(C1, 8'h01);
    w(3);
    chk(irq_a_n, 1'b0);
    rdc(C2, 8'h04);
    wr(C1, 8'h04);
    wr(`RTCK_IDX_SEC, 8'h00);
    wr(C2, 8'h00);
    w(2);
    chk(irq_a_n, 1'b1);
    w(200);
    chk(irq_a_n, 1'b0);
    rdc(C2, 8'h04);
    wr(C2, 8'h04);
    rdc(C2, 8'h04);
    wr(C2, 8'h00);
    w(2);
    chk(irq_a_n, 1'b1);
    rdc(C2, 8'h00);
    for (int c = 2; c < 8; c++) wr(C1, 8'(c));
    wr(C1, 8'h05);
    wr(`RTCK_IDX_SEC, 8'h58);
    wr(C2, 8'h00);
    w(200);
    rdc(C2, 8'h00);
    w(100);
    rdc(C2, 8'h04);
    wr(C1, 8'h80);
    wr(C2, 8'h00);
    hit(1'b0);
    w(355);
    rdc(C2, 8'h00);
    w(20);
    rdc(C2, 8'h02);
    chk(irq_a_n, 1'b0);
    wr(C2, 8'h77);
    rdc(C2, 8'h02);
    wr(C2, 8'h75);
    w(2);
    chk(irq_a_n, 1'b1);
    wr(C1, 8'h00);
    hit(1'b1);
    w(400);
    rdc(C2, 8'h00);
    chk(irq_b_n, 1'b1);
    wr(C1, 8'h40);
    hit(1'b1);
    w(400);
    chk(irq_b_n, 1'b0);
    rdc(C2, 8'h01);
    wr(C1, 8'h00);
    rdc(C2, 8'h00);
    osc_run <= 1'b0;
    w(3000);
    rdc(C2, 8'h20);
    osc_run <= 1'b1;
    w(20);
    wr(C2, 8'h20);
    rdc(C2, 8'h20);
    wr(C2, 8'h00);
    rdc(C2, 8'h00);
    end_sim();
  end
endmodule // rtc_timekeeping_and_flags_tb_top
bind rtck_core rtck_core_chk #(.AW(AW)) chk (.*);
